// ===== hdl/frpwc_timer.v
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "frpwc_defs.vh"
// Overview of operation
// RL1 - Mode 110 measures pulse widths after enable
// RL2 - PWM edge: capture, clear counter, interrupt
// RL3 - Past FFFFH: overflow irq, wrap, flag set
// RL4 - Software enables only one trigger input
// RL5 - External clock on input 0, edge none
// RL6 - Overflow flag cleared by bit or write
// RL7 - Overflow beats a simultaneous bit clear
// RL8 - Software checks flag before clearing it
// RL9 - Two independent compare interval interrupts
// RL10 - Software reloads compare with previous plus interval
// RL11 - Free-run captures on two separate inputs
// RL12 - Software keeps per-channel overflow copies
// RL13 - Software counts multiple wraps itself
// RL14 - Software adds 10000H per flagged overflow
// RL15 - Mode 101 free-runs and wraps after enable
// RL16 - Per-register capture or compare selection
// RL17 - Free-run capture keeps counter running
// RL18 - Edge effects land on one count clock
module frpwc_timer (
  ref_clk,
  rstn,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  captureInput0,
  captureInput1,
  captureCompareIrq0,
  captureCompareIrq1,
  overflowIrq,
  irq
);
  input ref_clk;
  input rstn;
  input psel;
  input penable;
  input pwrite;
  input [11:0] paddr;
  input [31:0] pwdata;
  output [31:0] prdata;
  output pready;
  output pslverr;
  input captureInput0;
  input captureInput1;
  output captureCompareIrq0;
  output captureCompareIrq1;
  output overflowIrq;
  output irq;

  reg [31:0] prdata;
  reg pready;
  reg pslverr;
  reg captureCompareIrq0;
  reg captureCompareIrq1;
  reg overflowIrq;
  reg irq;

  reg [7:0] controlReg0_r;
  reg [7:0] optionReg0_r;
  reg [3:0] edgeSelectReg_r;
  reg [15:0] ccReg0_r;
  reg [15:0] ccReg1_r;
  reg [15:0] count_r;
  reg [2:0] intStat_r;
  reg [2:0] intMask_r;
  reg [31:0] rdMux;

  wire edgeHit0;
  wire edgeHit1;
  wire tick;

  // =====================================================================
  // Decoding helpers
  function isAddr;
    input [11:0] addr;
    input [11:0] off;
    begin
      isAddr = (addr == off);
    end
  endfunction

  // Compare hit between count and a capture/compare register
  function ccMatch;
    input [15:0] cnt;
    input [15:0] cmpVal;
    begin
      ccMatch = (cnt == cmpVal);
    end
  endfunction

  // Bus strobes and decoded control fields
  wire access = psel & penable & pready;
  wire wrStb = access & pwrite;
  wire countEnableBit = controlReg0_r[`FRPWC_CTL0_CE];
  wire [2:0] mode = controlReg0_r[`FRPWC_CTL0_MD_HI:`FRPWC_CTL0_MD_LO];
  wire modeFree = (mode == `FRPWC_MODE_FREERUN);
  wire modePwm = (mode == `FRPWC_MODE_PWM);
  wire running = countEnableBit & (modeFree | modePwm);
  wire extClk = controlReg0_r[`FRPWC_CTL0_EXTCLK];
  wire cc0CaptureSelect = optionReg0_r[`FRPWC_OPT0_CCS0];
  wire cc1CaptureSelect = optionReg0_r[`FRPWC_OPT0_CCS1];

  // =====================================================================
  // Input edge detection and count clock
  frpwc_edge_det u_edge0 (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .pinIn(captureInput0),
    .edgeSel(edgeSelectReg_r[1:0]),
    .edgeHit(edgeHit0)
  );

  frpwc_edge_det u_edge1 (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .pinIn(captureInput1),
    .edgeSel(edgeSelectReg_r[3:2]),
    .edgeHit(edgeHit1)
  );

  // External clock uses input 0 rising edges only
  wire extEdge;
  frpwc_edge_det u_extclk (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .pinIn(captureInput0),
    .edgeSel(`FRPWC_EDGE_RISE),
    .edgeHit(extEdge)
  );

  // Count clock enable from prescaler or input 0
  frpwc_clk_div u_div (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .run(running),
    .divSel(controlReg0_r[`FRPWC_CTL0_DIV_HI:`FRPWC_CTL0_DIV_LO]),
    .extSel(extClk),
    .extEdge(extEdge),
    .tick(tick)
  );

  // =====================================================================
  // Event qualification
  // Input 0 never triggers while it carries the count clock
  wire trig0 = edgeHit0 & ~extClk; // RL5
  wire trig1 = edgeHit1;
  wire capture0 = running & trig0 & (modePwm | cc0CaptureSelect); // RL16
  wire capture1 = running & trig1 & (modePwm | cc1CaptureSelect); // RL16
  wire pwmClear = modePwm & (capture0 | capture1); // RL2
  wire overflowEv = running & tick & (count_r == `FRPWC_CNT_TOP) & ~pwmClear; // RL3
  wire match0 = running & modeFree & ~cc0CaptureSelect & tick & ccMatch(count_r, ccReg0_r); // RL9
  wire match1 = running & modeFree & ~cc1CaptureSelect & tick & ccMatch(count_r, ccReg1_r); // RL9
  wire ccEv0 = capture0 | match0;
  wire ccEv1 = capture1 | match1;

  // =====================================================================
  // Register write strobes
  wire wrCtl = wrStb & isAddr(paddr, `FRPWC_OFF_CTL0);
  wire wrIoc = wrStb & isAddr(paddr, `FRPWC_OFF_IOC1);
  wire wrMask = wrStb & isAddr(paddr, `FRPWC_OFF_IMASK);
  wire wrStat = wrStb & isAddr(paddr, `FRPWC_OFF_ISTAT);
  wire wrOpt = wrStb & isAddr(paddr, `FRPWC_OFF_OPT0);
  wire bitClr = wrStb & isAddr(paddr, `FRPWC_OFF_OVCLR) & pwdata[`FRPWC_OPT0_OVF];
  wire wrCcr0 = wrStb & isAddr(paddr, `FRPWC_OFF_CCR0);
  wire wrCcr1 = wrStb & isAddr(paddr, `FRPWC_OFF_CCR1);

  // =====================================================================
  // Counter
  // Next count when a count clock arrives
  wire [15:0] countPlusOne = count_r + 16'h0001;

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      count_r <= `FRPWC_CNT_ZERO;
    end else if (!running) begin
      count_r <= `FRPWC_CNT_ZERO;
    end else if (pwmClear) begin
      count_r <= `FRPWC_CNT_ZERO; // RL2
    end else if (tick) begin
      count_r <= countPlusOne; // RL3 RL15
    end
  end

  // =====================================================================
  // Capture/compare registers, hardware capture over software write
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ccReg0_r <= `FRPWC_RST_CCR;
      ccReg1_r <= `FRPWC_RST_CCR;
    end else begin
      // Channel 0: capture beats a bus write
      if (capture0) begin
        ccReg0_r <= count_r; // RL2 RL17 RL18
      end else if (wrCcr0) begin
        ccReg0_r <= pwdata[15:0];
      end
      // Channel 1 mirrors channel 0
      if (capture1) begin
        ccReg1_r <= count_r; // RL11 RL17 RL18
      end else if (wrCcr1) begin
        ccReg1_r <= pwdata[15:0];
      end
    end
  end

  // =====================================================================
  // Control and option registers
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      controlReg0_r <= `FRPWC_RST_CTL0;
      optionReg0_r <= `FRPWC_RST_OPT0;
      edgeSelectReg_r <= `FRPWC_RST_IOC1;
    end else begin
      // Control: enable, prescale, source, mode
      if (wrCtl) begin
        controlReg0_r <= pwdata[7:0]; // RL1 RL15
      end
      // Edge selects, two bits per input
      if (wrIoc) begin
        edgeSelectReg_r <= pwdata[3:0];
      end
      // Select bits from byte write; overflow flag set wins
      if (wrOpt) begin
        optionReg0_r[7:1] <= pwdata[7:1];
      end
      if (overflowEv) begin
        optionReg0_r[`FRPWC_OPT0_OVF] <= 1'b1; // RL3 RL7
      end else if (bitClr) begin
        optionReg0_r[`FRPWC_OPT0_OVF] <= 1'b0; // RL6
      end else if (wrOpt & ~pwdata[`FRPWC_OPT0_OVF]) begin
        optionReg0_r[`FRPWC_OPT0_OVF] <= 1'b0; // RL6
      end
    end
  end

  // =====================================================================
  // Interrupt pulses, sticky status, mask and level output
  // Sticky status: write-one clears, new events win
  wire [2:0] statClr = wrStat ? pwdata[2:0] : 3'h0;
  wire [2:0] statSet = {overflowEv, ccEv1, ccEv0};
  wire irqLevel = |(intStat_r & intMask_r);

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      captureCompareIrq0 <= 1'b0;
      captureCompareIrq1 <= 1'b0;
      overflowIrq <= 1'b0;
      intStat_r <= 3'h0;
      intMask_r <= 3'h0;
      irq <= 1'b0;
    end else begin
      captureCompareIrq0 <= ccEv0; // RL2 RL18
      captureCompareIrq1 <= ccEv1; // RL18
      overflowIrq <= overflowEv; // RL3
      if (wrMask) begin
        intMask_r <= pwdata[2:0];
      end
      // Set wins when an event meets its clear
      intStat_r <= (intStat_r & ~statClr) | statSet;
      // Level output, one cycle behind status
      irq <= irqLevel;
    end
  end

  // =====================================================================
  // APB read mux
  always @* begin
    rdMux = 32'h00000000;
    case (paddr)
      `FRPWC_OFF_CTL0: rdMux = {24'h000000, controlReg0_r};
      `FRPWC_OFF_OPT0: rdMux = {24'h000000, optionReg0_r};
      `FRPWC_OFF_IOC1: rdMux = {28'h0000000, edgeSelectReg_r};
      `FRPWC_OFF_CCR0: rdMux = {16'h0000, ccReg0_r};
      `FRPWC_OFF_CCR1: rdMux = {16'h0000, ccReg1_r};
      `FRPWC_OFF_CNT: rdMux = {16'h0000, count_r};
      `FRPWC_OFF_ISTAT: rdMux = {29'h00000000, intStat_r};
      `FRPWC_OFF_IMASK: rdMux = {29'h00000000, intMask_r};
      `FRPWC_OFF_OVCLR: rdMux = 32'h00000000;
      default: rdMux = 32'h00000000;
    endcase
  end

  // =====================================================================
  // Refused access: misaligned or past the last register
  wire badAddr = (paddr[1:0] != 2'h0) | (paddr > `FRPWC_OFF_OVCLR);

  // One wait state: pready registered in access phase
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      // Answer in the second access cycle only
      if (psel & penable & ~pready) begin
        pready <= 1'b1;
        prdata <= rdMux;
        pslverr <= badAddr;
      end else begin
        pready <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end
endmodule // frpwc_timer

// ===== hdl/frpwc_defs.vh
`ifndef FRPWC_DEFS_VH
`define FRPWC_DEFS_VH

// =====================================================================
// Register byte offsets
`define FRPWC_OFF_CTL0 12'h000
`define FRPWC_OFF_OPT0 12'h004
`define FRPWC_OFF_IOC1 12'h008
`define FRPWC_OFF_CCR0 12'h00c
`define FRPWC_OFF_CCR1 12'h010
`define FRPWC_OFF_CNT 12'h014
`define FRPWC_OFF_ISTAT 12'h018
`define FRPWC_OFF_IMASK 12'h01c
`define FRPWC_OFF_OVCLR 12'h020

// =====================================================================
// Control register 0 fields
`define FRPWC_CTL0_CE 7
`define FRPWC_CTL0_MD_HI 2
`define FRPWC_CTL0_MD_LO 0
`define FRPWC_CTL0_DIV_HI 6
`define FRPWC_CTL0_DIV_LO 4
`define FRPWC_CTL0_EXTCLK 3
`define FRPWC_MODE_FREERUN 3'h5
`define FRPWC_MODE_PWM 3'h6

// =====================================================================
// Option register 0 fields
`define FRPWC_OPT0_OVF 0
`define FRPWC_OPT0_CCS0 4
`define FRPWC_OPT0_CCS1 5

// =====================================================================
// Edge select: two bits per input
`define FRPWC_EDGE_NONE 2'h0
`define FRPWC_EDGE_RISE 2'h1
`define FRPWC_EDGE_FALL 2'h2
`define FRPWC_EDGE_BOTH 2'h3

// =====================================================================
// Interrupt status bits
`define FRPWC_IRQ_CC0 0
`define FRPWC_IRQ_CC1 1
`define FRPWC_IRQ_OV 2

// =====================================================================
// Reset values and counter top
`define FRPWC_RST_CTL0 8'h00
`define FRPWC_RST_OPT0 8'h00
`define FRPWC_RST_IOC1 4'h0
`define FRPWC_RST_CCR 16'h0000
`define FRPWC_CNT_TOP 16'hffff
`define FRPWC_CNT_ZERO 16'h0000

`endif

// ===== hdl/frpwc_edge_det.v
`timescale 1ns/1ps
// =====================================================================
// Pin synchroniser and programmable edge detector
module frpwc_edge_det (
  ref_clk,
  rstn,
  pinIn,
  edgeSel,
  edgeHit
);
  input ref_clk;
  input rstn;
  input pinIn;
  input [1:0] edgeSel;
  output edgeHit;

  reg syncA_r;
  reg syncB_r;
  reg prev_r;
  reg edgeHit;

  // Two-stage synchroniser, then edge history
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      syncA_r <= 1'b0;
      syncB_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      syncA_r <= pinIn;
      syncB_r <= syncA_r;
      prev_r <= syncB_r;
    end
  end

  // Edge qualification by selection
  always @* begin
    case (edgeSel)
      2'h1: edgeHit = syncB_r & ~prev_r;
      2'h2: edgeHit = ~syncB_r & prev_r;
      2'h3: edgeHit = syncB_r ^ prev_r;
      default: edgeHit = 1'b0;
    endcase
  end
endmodule // frpwc_edge_det

// ===== hdl/frpwc_clk_div.v
`timescale 1ns/1ps
// =====================================================================
// Count clock enable: prescaler or external clock edge
module frpwc_clk_div (
  ref_clk,
  rstn,
  run,
  divSel,
  extSel,
  extEdge,
  tick
);
  input ref_clk;
  input rstn;
  input run;
  input [2:0] divSel;
  input extSel;
  input extEdge;
  output tick;

  reg [7:0] pre_r;
  reg tick;

  // Free prescaler, cleared while stopped
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pre_r <= 8'h00;
    end else if (!run) begin
      pre_r <= 8'h00;
    end else begin
      pre_r <= pre_r + 8'h01;
    end
  end

  // Select rate 2^divSel or external edge
  always @* begin
    if (!run) begin
      tick = 1'b0;
    end else if (extSel) begin
      tick = extEdge;
    end else if (divSel == 3'h0) begin
      tick = 1'b1;
    end else begin
      tick = ((pre_r & ((8'h01 << divSel) - 8'h01)) == 8'h00);
    end
  end
endmodule // frpwc_clk_div

// ===== test/frpwc_timer_props.sv
`timescale 1ns/1ps
// ===================================
// Port timing checks
module frpwc_timer_props (
  input wire ref_clk,
  input wire rstn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire captureInput0,
  input wire captureInput1,
  input wire captureCompareIrq0,
  input wire captureCompareIrq1,
  input wire overflowIrq,
  input wire irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_ready_walk: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response without pready or with data");
  a_cc0_pulse: assert property (captureCompareIrq0 |=> !captureCompareIrq0)
    else $error("channel 0 interrupt not a single pulse");
  a_cc1_pulse: assert property (captureCompareIrq1 |=> !captureCompareIrq1)
    else $error("channel 1 interrupt not a single pulse");
  a_ov_space: assert property (overflowIrq |=> !overflowIrq [*8])
    else $error("overflow pulses too close");
  a_start_quiet: assert property ($rose(rstn) |-> !pready && !irq && !overflowIrq)
    else $error("outputs active right after reset");
  a_irq_drop: assert property ($fell(irq) |->
    $past(pwrite && pready, 2) || $past(pwrite && pready, 3))
    else $error("interrupt dropped without a write");
endmodule // frpwc_timer_props

bind frpwc_timer frpwc_timer_props chk (.ref_clk(ref_clk), .rstn(rstn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .captureInput0(captureInput0),
  .captureInput1(captureInput1), .captureCompareIrq0(captureCompareIrq0),
  .captureCompareIrq1(captureCompareIrq1), .overflowIrq(overflowIrq), .irq(irq));

// ===== test/frpwc_pin_model.sv
`timescale 1ns/1ps
// ===================================
// Capture pin source: high pulse of given width
module frpwc_pin_model (
  input wire ref_clk,
  input wire rstn,
  input wire fire,
  input wire [15:0] width,
  output logic pinOut
);
  logic [15:0] left_r;
  // Pulse timer, pin idles low
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      left_r <= 16'h0000;
      pinOut <= 1'b0;
    end else if (fire) begin
      left_r <= width;
      pinOut <= 1'b1;
    end else if (left_r > 16'h0001) begin
      left_r <= left_r - 16'h0001;
    end else begin
      left_r <= 16'h0000;
      pinOut <= 1'b0;
    end
  end
endmodule // frpwc_pin_model

// ===== test/testbench.sv
`timescale 1ns/1ps
`include "frpwc_defs.vh"
// ===================================
// Timer bench
module testbench;
  logic ref_clk, rstn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed, lastRd;
  logic pin0, pin1, ccIrq0, ccIrq1, ovIrq, fire0, fire1;
  logic [15:0] w0, w1;
  logic [31:0] expQ[$], mskQ[$];
  logic errQ[$];
  int n_mismatch = 0, checks_done = 0, cnt0 = 0, cnt1 = 0, cntOv = 0, cyc = 0;
  int d, n, t0, v;
  int expCap[4] = '{0, 1, 1, 2};
  frpwc_timer DUT (.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .captureInput0(pin0), .captureInput1(pin1),
    .captureCompareIrq0(ccIrq0), .captureCompareIrq1(ccIrq1), .overflowIrq(ovIrq),
    .irq(irq));
  frpwc_pin_model src0 (.ref_clk(ref_clk), .rstn(rstn), .fire(fire0), .width(w0),
    .pinOut(pin0));
  frpwc_pin_model src1 (.ref_clk(ref_clk), .rstn(rstn), .fire(fire1), .width(w1),
    .pinOut(pin1));
  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  function automatic [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic cmp(input string nm, input [31:0] e, input [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrap_up;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ===================================
  // Bus transfers, read expectations queued
  task automatic apb(input w, input [11:0] a, input [31:0] dt, input [31:0] e, input [31:0] m);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dt;
    errQ.push_back(a[1:0] != 2'h0 || a > `FRPWC_OFF_OVCLR);
    if (!w) begin
      expQ.push_back(e);
      mskQ.push_back(m);
    end
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1 && k < 20) begin
      k++;
      @(posedge ref_clk);
    end
    if (k == 20) cmp("pready", 1, 0);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input [11:0] a, input [31:0] dt);
    apb(1'b1, a, dt, 0, 0);
  endtask
  task automatic rd(input [11:0] a, input [31:0] e, input [31:0] m);
    apb(1'b0, a, 0, e, m);
  endtask
  task automatic pulse(input int p, input [15:0] w);
    if (p == 0) begin
      w0 <= w;
      fire0 <= 1'b1;
    end else begin
      w1 <= w;
      fire1 <= 1'b1;
    end
    @(posedge ref_clk);
    fire0 <= 1'b0;
    fire1 <= 1'b0;
  endtask
  // Read data watcher and event counters
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    cnt0 <= cnt0 + ccIrq0;
    cnt1 <= cnt1 + ccIrq1;
    cntOv <= cntOv + ovIrq;
    if (psel && penable && pready && errQ.size() > 0) begin
      cmp("pslverr", errQ.pop_front(), pslverr);
    end
    if (psel && penable && pready && !pwrite && expQ.size() > 0) begin
      lastRd = prdata;
      cmp("prdata", expQ.pop_front(), prdata & mskQ.pop_front());
    end
  end
  // Watchdog
  initial begin
    #800000;
    n_mismatch++;
    wrap_up();
  end
  // ===================================
  // Main sequence
  initial begin
    rstn = 1'b0;
    {psel, penable, pwrite, fire0, fire1} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    w0 = 16'h0000;
    w1 = 16'h0000;
    seed = 32'hfe0c;
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    rd(`FRPWC_OFF_CTL0, 0, 32'hffffffff);
    rd(`FRPWC_OFF_OPT0, 0, 32'hffffffff);
    rd(`FRPWC_OFF_IOC1, 0, 32'hffffffff);
    rd(12'h024, 0, 32'hffffffff);
    seed = lfsr(seed);
    d = 16 + seed[5:0];
    wr(`FRPWC_OFF_CCR0, d - 1);
    wr(`FRPWC_OFF_CCR1, d + 9);
    wr(`FRPWC_OFF_IMASK, 7);
    wr(`FRPWC_OFF_CTL0, 32'h85);
    repeat (150) @(posedge ref_clk);
    cmp("cc0 count", 1, cnt0);
    cmp("cc1 count", 1, cnt1);
    cmp("irq", 1, irq);
    rd(`FRPWC_OFF_ISTAT, 3, 3);
    wr(`FRPWC_OFF_ISTAT, 3);
    rd(`FRPWC_OFF_ISTAT, 0, 3);
    wr(`FRPWC_OFF_OPT0, 32'h10);
    wr(`FRPWC_OFF_IOC1, 1);
    seed = lfsr(seed);
    d = 100 + seed[7:0];
    t0 = cyc;
    pulse(0, 10);
    repeat (20) @(posedge ref_clk);
    rd(`FRPWC_OFF_CCR0, 0, 32'hffff0000);
    v = lastRd;
    while (cyc < t0 + d) @(posedge ref_clk);
    pulse(0, 10);
    repeat (20) @(posedge ref_clk);
    rd(`FRPWC_OFF_CCR0, (v + d) & 32'hffff, 32'hffff);
    n = 0;
    while (cntOv == 0 && n < 70000) begin
      n++;
      @(posedge ref_clk);
    end
    cmp("overflow", 1, cntOv);
    rd(`FRPWC_OFF_OPT0, 1, 1);
    rd(`FRPWC_OFF_ISTAT, 4, 4);
    wr(`FRPWC_OFF_IMASK, 0);
    repeat (3) @(posedge ref_clk);
    cmp("irq masked", 0, irq);
    wr(`FRPWC_OFF_OPT0, 1);
    rd(`FRPWC_OFF_OPT0, 1, 1);
    wr(`FRPWC_OFF_OVCLR, 1);
    rd(`FRPWC_OFF_OPT0, 0, 1);
    // Prescaled free-run: compare at 40 needs four clocks a count
    wr(`FRPWC_OFF_CTL0, 0);
    wr(`FRPWC_OFF_CCR1, 40);
    wr(`FRPWC_OFF_CTL0, 32'ha5);
    v = cnt1;
    repeat (120) @(posedge ref_clk);
    cmp("slow cc1 early", 0, cnt1 - v);
    repeat (100) @(posedge ref_clk);
    cmp("slow cc1 count", 1, cnt1 - v);
    for (int e = 0; e < 4; e++) begin
      wr(`FRPWC_OFF_CTL0, 0);
      wr(`FRPWC_OFF_IOC1, e << 2);
      wr(`FRPWC_OFF_CTL0, 32'h86);
      v = cnt1;
      pulse(1, d);
      repeat (d + 20) @(posedge ref_clk);
      cmp("captures", expCap[e], cnt1 - v);
    end
    rd(`FRPWC_OFF_CCR1, d - 1, 32'hffff);
    // External count clock on input 0, width measured on input 1
    seed = lfsr(seed);
    n = 5 + seed[3:0];
    wr(`FRPWC_OFF_CTL0, 0);
    wr(`FRPWC_OFF_IOC1, 12);
    wr(`FRPWC_OFF_CTL0, 32'h8e);
    v = cnt1;
    pulse(1, 3 * n + 3);
    repeat (n) begin
      repeat (2) @(posedge ref_clk);
      pulse(0, 1);
    end
    repeat (20) @(posedge ref_clk);
    cmp("ext captures", 2, cnt1 - v);
    rd(`FRPWC_OFF_CCR1, n, 32'hffff);
    wrap_up();
  end
endmodule // testbench
